/* src/fsrg_gate.v */
// Suspend and resume command gate of a serial flash device.
// Assumes the serial pins come from an outside host in mode 0 and the
// command class, operation start and done strobes come from logic on clk.
//
// Notes on behaviour
// - Reads always allowed in every suspend state.
// - Buffer write refused only to suspended program buffer.
// - Erasing program commands and erases refused in every suspend state.
// - In a suspend state, program without erase allowed only in erase suspend.
// - Protection and security modifying commands refused.
// - Array to buffer transfer refused into suspended buffer.
// - Array to buffer compares always allowed.
// - Power-down entry and its resume refused.
// - Hardware or software reset always carried out.
// - Resume is opcode D0h; later bytes ignored.
// - Resume restarts operation within latency limit.
// - Resume clears the applicable suspend flag.
// - Ready-busy shows busy while resumed operation runs.
// - Dual suspend resumes program first, erase waits.
// - Suspend ignored while a resume is in progress.
// - Suspend opcode B0h sets flag and reports ready.
`timescale 1ns/100ps
`include "fsrg_defines.vh"

module fsrg_gate
#(
  parameter RESUME_CYCLES = `FSRG_RESUME_CYCLES,
  parameter CNT_W = 16
)
(
  // Clock and reset.
  input wire clk,
  input wire rst_n,
  // Serial pins from the host.
  input wire sck,
  input wire cs_n,
  input wire si,
  // Command classification from the main decoder.
  input wire cmd_valid,
  input wire [3:0] cmd_class,
  // Array operation events.
  input wire op_start,
  input wire [1:0] op_kind,
  input wire op_done,
  input wire soft_reset,
  // Gate answer.
  output reg gate_allow_reg,
  output reg gate_refuse_reg,
  // Commands to the array sequencer.
  output reg suspend_cmd_reg,
  output reg resume_cmd_reg,
  output reg [1:0] resume_kind_reg,
  output reg reset_cmd_reg,
  // Status.
  output reg ready_reg,
  output reg resuming_reg,
  output reg prog_suspend_buf_one_flag,
  output reg prog_suspend_buf_two_flag,
  output reg erase_suspend_flag
);

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  reg [2:0] sck_sync_reg;
  reg [2:0] cs_sync_reg;
  reg [1:0] si_sync_reg;
  wire sck_rise;
  wire cs_rise;
  wire cs_fall;
  wire cs_low;

  // Two flops per pin, a third only on the clock and select for edges.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_sync_reg <= 3'h0;
      cs_sync_reg <= 3'h7;
      si_sync_reg <= 2'h0;
    end
    else
    begin
      sck_sync_reg <= {sck_sync_reg[1:0], sck};
      cs_sync_reg <= {cs_sync_reg[1:0], cs_n};
      si_sync_reg <= {si_sync_reg[0], si};
    end
  end

  assign sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
  assign cs_rise = cs_sync_reg[1] & ~cs_sync_reg[2];
  assign cs_fall = ~cs_sync_reg[1] & cs_sync_reg[2];
  assign cs_low = ~cs_sync_reg[1];

  // ****************************************************************
  // Opcode capture
  // ****************************************************************
  reg [7:0] opcode_reg;
  reg [3:0] bit_cnt_reg;

  // Only the first byte of a frame is kept; the rest is discarded.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      opcode_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
    end
    else if (cs_fall)
    begin
      bit_cnt_reg <= 4'h0;
    end
    else if (cs_low && sck_rise && bit_cnt_reg != `FSRG_OPCODE_BITS)
    begin
      opcode_reg <= {opcode_reg[6:0], si_sync_reg[1]};
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  wire frame_end;
  wire suspend_seen;
  wire resume_seen;

  assign frame_end = cs_rise && bit_cnt_reg == `FSRG_OPCODE_BITS;
  assign suspend_seen = frame_end && opcode_reg == `FSRG_OP_SUSPEND;
  assign resume_seen = frame_end && opcode_reg == `FSRG_OP_RESUME;

  // ****************************************************************
  // Command gating in the suspend states
  // ****************************************************************
  reg allow_c;
  wire any_susp;
  wire ps1;
  wire ps2;
  wire es;

  assign ps1 = prog_suspend_buf_one_flag;
  assign ps2 = prog_suspend_buf_two_flag;
  assign es = erase_suspend_flag;
  assign any_susp = ps1 | ps2 | es;

  // Decide whether the classified command may run now.
  always @*
  begin
    allow_c = 1'b1;
    if (any_susp)
    begin
      case (cmd_class)
        `FSRG_CLS_READ: allow_c = 1'b1;
        `FSRG_CLS_WRITE_B1: allow_c = ~ps1;
        `FSRG_CLS_WRITE_B2: allow_c = ~ps2;
        `FSRG_CLS_XFER_B1: allow_c = ~ps1;
        `FSRG_CLS_XFER_B2: allow_c = ~ps2;
        `FSRG_CLS_COMPARE: allow_c = 1'b1;
        `FSRG_CLS_PROG_NOERASE: allow_c = ~(ps1 | ps2);
        `FSRG_CLS_ERASING: allow_c = 1'b0;
        `FSRG_CLS_PROT_MODIFY: allow_c = 1'b0;
        `FSRG_CLS_POWER_DOWN: allow_c = 1'b0;
        `FSRG_CLS_RESET: allow_c = 1'b1;
        default: allow_c = 1'b1;
      endcase
    end
  end

  // Register the answer as one-cycle pulses.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gate_allow_reg <= 1'b0;
      gate_refuse_reg <= 1'b0;
    end
    else
    begin
      gate_allow_reg <= cmd_valid & allow_c;
      gate_refuse_reg <= cmd_valid & ~allow_c;
    end
  end

  // ****************************************************************
  // Suspend and resume sequencing
  // ****************************************************************
  reg [1:0] running_reg;
  reg [CNT_W-1:0] res_cnt_reg;
  wire do_reset;
  wire do_suspend;
  wire do_resume;
  wire [1:0] res_kind;

  assign do_reset = soft_reset | (cmd_valid && cmd_class == `FSRG_CLS_RESET);
  // A suspend only counts while an operation runs and no resume is in flight.
  assign do_suspend = suspend_seen && running_reg != `FSRG_OPK_NONE && !resuming_reg;
  // A pending program goes first when both kinds are suspended.
  assign do_resume = resume_seen && running_reg == `FSRG_OPK_NONE && any_susp;
  assign res_kind = ps1 ? `FSRG_OPK_PROG_B1 : ps2 ? `FSRG_OPK_PROG_B2 : `FSRG_OPK_ERASE;

  // Flags, running operation, ready and the resume window.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      running_reg <= `FSRG_OPK_NONE;
      prog_suspend_buf_one_flag <= 1'b0;
      prog_suspend_buf_two_flag <= 1'b0;
      erase_suspend_flag <= 1'b0;
      ready_reg <= 1'b1;
      resuming_reg <= 1'b0;
      res_cnt_reg <= {CNT_W{1'b0}};
      suspend_cmd_reg <= 1'b0;
      resume_cmd_reg <= 1'b0;
      resume_kind_reg <= `FSRG_OPK_NONE;
      reset_cmd_reg <= 1'b0;
    end
    else
    begin
      // A reset in the same cycle aborts the suspend, so no pulse is sent.
      suspend_cmd_reg <= do_suspend & ~do_reset;
      resume_cmd_reg <= do_resume & ~do_reset;
      reset_cmd_reg <= do_reset;
      if (do_reset)
      begin
        // Reset aborts every suspended or running operation.
        running_reg <= `FSRG_OPK_NONE;
        prog_suspend_buf_one_flag <= 1'b0;
        prog_suspend_buf_two_flag <= 1'b0;
        erase_suspend_flag <= 1'b0;
        ready_reg <= 1'b1;
        resuming_reg <= 1'b0;
        res_cnt_reg <= {CNT_W{1'b0}};
      end
      else if (do_suspend)
      begin
        running_reg <= `FSRG_OPK_NONE;
        ready_reg <= 1'b1;
        case (running_reg)
          `FSRG_OPK_PROG_B1: prog_suspend_buf_one_flag <= 1'b1;
          `FSRG_OPK_PROG_B2: prog_suspend_buf_two_flag <= 1'b1;
          default: erase_suspend_flag <= 1'b1;
        endcase
      end
      else if (do_resume)
      begin
        running_reg <= res_kind;
        resume_kind_reg <= res_kind;
        ready_reg <= 1'b0;
        resuming_reg <= 1'b1;
        res_cnt_reg <= RESUME_CYCLES[CNT_W-1:0];
        case (res_kind)
          `FSRG_OPK_PROG_B1: prog_suspend_buf_one_flag <= 1'b0;
          `FSRG_OPK_PROG_B2: prog_suspend_buf_two_flag <= 1'b0;
          default: erase_suspend_flag <= 1'b0;
        endcase
      end
      else
      begin
        // Count out the resume window; suspends are ignored until it ends.
        if (resuming_reg)
        begin
          res_cnt_reg <= res_cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
          if (res_cnt_reg <= {{(CNT_W-1){1'b0}}, 1'b1})
          begin
            resuming_reg <= 1'b0;
          end
        end
        if (op_done)
        begin
          running_reg <= `FSRG_OPK_NONE;
          ready_reg <= 1'b1;
          resuming_reg <= 1'b0;
        end
        else if (op_start && running_reg == `FSRG_OPK_NONE)
        begin
          running_reg <= op_kind;
          ready_reg <= (op_kind == `FSRG_OPK_NONE);
        end
      end
    end
  end

endmodule

/* inc/fsrg_defines.vh */
// Constants for the suspend and resume command gate of the serial flash.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef FSRG_DEFINES_VH
`define FSRG_DEFINES_VH

// ****************************************************************
// Opcodes taken directly from the serial input
// ****************************************************************
`define FSRG_OP_SUSPEND 8'hB0
`define FSRG_OP_RESUME 8'hD0
`define FSRG_OPCODE_BITS 4'h8

// ****************************************************************
// Command classes supplied by the main command decoder
// ****************************************************************
`define FSRG_CLS_READ 4'h0
`define FSRG_CLS_WRITE_B1 4'h1
`define FSRG_CLS_WRITE_B2 4'h2
`define FSRG_CLS_XFER_B1 4'h3
`define FSRG_CLS_XFER_B2 4'h4
`define FSRG_CLS_COMPARE 4'h5
`define FSRG_CLS_PROG_NOERASE 4'h6
`define FSRG_CLS_ERASING 4'h7
`define FSRG_CLS_PROT_MODIFY 4'h8
`define FSRG_CLS_POWER_DOWN 4'h9
`define FSRG_CLS_RESET 4'hA
`define FSRG_CLS_OTHER 4'hB

// ****************************************************************
// Operation kinds on the array side
// ****************************************************************
`define FSRG_OPK_NONE 2'h0
`define FSRG_OPK_PROG_B1 2'h1
`define FSRG_OPK_PROG_B2 2'h2
`define FSRG_OPK_ERASE 2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define FSRG_CLK_PERIOD_NS 10
`define FSRG_RESUME_LATENCY_NS 50000
`define FSRG_RESUME_CYCLES (`FSRG_RESUME_LATENCY_NS / `FSRG_CLK_PERIOD_NS)

`endif

/* bench/fsrg_checker.sv */
// Checker of the suspend gate outputs against its inputs.
// Assumes a bind into fsrg_gate; sees only its ports.
`timescale 1ns/100ps
`include "fsrg_defines.vh"
module fsrg_checker
(
  // Clock, reset and inputs.
  input wire clk,
  input wire rst_n,
  input wire cmd_valid,
  input wire [3:0] cmd_class,
  input wire soft_reset,
  // Outputs under check.
  input wire gate_allow_reg,
  input wire gate_refuse_reg,
  input wire suspend_cmd_reg,
  input wire resume_cmd_reg,
  input wire [1:0] resume_kind_reg,
  input wire reset_cmd_reg,
  input wire ready_reg,
  input wire resuming_reg,
  input wire prog_suspend_buf_one_flag,
  input wire prog_suspend_buf_two_flag,
  input wire erase_suspend_flag
);
  // Short views of the flags and of a command free of reset.
  wire p1 = prog_suspend_buf_one_flag;
  wire p2 = prog_suspend_buf_two_flag;
  wire es = erase_suspend_flag;
  wire anyf = p1 | p2 | es;
  wire cv = cmd_valid & !soft_reset;
  wire [3:0] c = cmd_class;
  wire kf = resume_kind_reg == 2'h1 ? p1 : resume_kind_reg == 2'h2 ? p2 : es;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_resumed;
    !ready_reg ##0 resuming_reg ##0 !kf;
  endsequence
  property p_one; cv |=> gate_allow_reg != gate_refuse_reg; endproperty
  property p_free; cv && !anyf |=> gate_allow_reg; endproperty
  property p_read; cv && (c == `FSRG_CLS_READ || c == `FSRG_CLS_COMPARE) |=> gate_allow_reg; endproperty
  property p_never; cv && anyf && (c == `FSRG_CLS_ERASING || c == `FSRG_CLS_PROT_MODIFY ||
    c == `FSRG_CLS_POWER_DOWN) |=> gate_refuse_reg; endproperty
  property p_buf; cv && (p1 && (c == `FSRG_CLS_WRITE_B1 || c == `FSRG_CLS_XFER_B1) ||
    p2 && (c == `FSRG_CLS_WRITE_B2 || c == `FSRG_CLS_XFER_B2)) |=> gate_refuse_reg; endproperty
  property p_noer; cv && anyf && c == `FSRG_CLS_PROG_NOERASE |=> gate_allow_reg == $past(es && !p1 && !p2);
  endproperty
  property p_rst; soft_reset || cmd_valid && c == `FSRG_CLS_RESET |=> reset_cmd_reg && !anyf && ready_reg;
  endproperty
  property p_res; resume_cmd_reg |-> s_resumed; endproperty
  property p_dual; resume_cmd_reg && $past(es) && $past(p1 || p2) |-> es; endproperty
  property p_nosusp; resuming_reg && $past(resuming_reg) |-> !suspend_cmd_reg; endproperty
  property p_susp; suspend_cmd_reg |-> ready_reg && anyf; endproperty
  a_one: assert property (p_one) else $error("gate answer not single");
  a_free: assert property (p_free) else $error("refusal with no suspend");
  a_read: assert property (p_read) else $error("read or compare refused");
  a_never: assert property (p_never) else $error("erasing class allowed");
  a_buf: assert property (p_buf) else $error("suspended buffer used");
  a_noer: assert property (p_noer) else $error("program without erase wrong");
  a_rst: assert property (p_rst) else $error("reset not carried out");
  a_res: assert property (p_res) else $error("resume status wrong");
  a_dual: assert property (p_dual) else $error("dual resume took erase");
  a_nosusp: assert property (p_nosusp) else $error("suspend during resume");
  a_susp: assert property (p_susp) else $error("suspend status wrong");
endmodule

/* bench/fsrg_host.sv */
// Host serial controller model that frames single opcodes.
// Assumes mode 0 and a bench that calls its frame task.
`timescale 1ns/100ps
module fsrg_host
(
  // Serial pins towards the gate.
  output logic sck,
  output logic cs_n,
  output logic si
);
  // Idle: clock still low, chip not selected.
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // Opcode MSB first, then filler bits that must be ignored.
  task frame(input logic [7:0] op, input int extra);
    logic [7:0] b;
    b = op;
    cs_n = 1'b0;
    for (int i = 0; i < 8 + extra; i++)
    begin
      si = b[7];
      b = {b[6:0], ~b[7]};
      #62.5 sck = 1'b1;
      #62.5 sck = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    si = ~si;
    #100;
  endtask
endmodule

/* bench/test_flash_suspend_resume_gate.sv */
// Bench of the suspend gate with a serial host model.
// Assumes the gate, its defines and the host model are compiled first.
`timescale 1ns/100ps
module test_flash_suspend_resume_gate;
  logic clk, rst_n, cmd_valid, op_start, op_done, soft_reset;
  logic [3:0] cmd_class;
  logic [1:0] op_kind;
  wire sck, cs_n, si, alw, rfs, susp, res, ready, ps1, ps2, es;
  wire [1:0] kind;
  int bad_count = 0, tests_run = 0, n_susp = 0, n_res = 0;
  fsrg_host host (.sck(sck), .cs_n(cs_n), .si(si));
  fsrg_gate #(.RESUME_CYCLES(300)) uut (.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si),
    .cmd_valid(cmd_valid), .cmd_class(cmd_class), .op_start(op_start), .op_kind(op_kind), .op_done(op_done),
    .soft_reset(soft_reset), .gate_allow_reg(alw), .gate_refuse_reg(rfs), .suspend_cmd_reg(susp),
    .resume_cmd_reg(res), .resume_kind_reg(kind), .reset_cmd_reg(), .ready_reg(ready), .resuming_reg(),
    .prog_suspend_buf_one_flag(ps1), .prog_suspend_buf_two_flag(ps2), .erase_suspend_flag(es));
  // Clock of 10 ns and counters of the one-cycle command pulses.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    n_susp += (susp === 1'b1);
    n_res += (res === 1'b1);
  end
  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task gate(input logic [3:0] c, input logic a);
    @(negedge clk) cmd_valid = 1'b1;
    cmd_class = c;
    @(negedge clk) cmd_valid = 1'b0;
    check("allow", alw, a);
    check("refuse", rfs, !a);
  endtask
  // Every class but reset against a mask of allowed classes.
  task sweep(input logic [11:0] m);
    for (int i = 0; i < 12; i++)
      if (i != 10)
        gate(i[3:0], m[i]);
  endtask
  task arr(input logic s, input logic d, input logic [1:0] k);
    @(negedge clk) op_start = s;
    op_done = d;
    op_kind = k;
    @(negedge clk) op_start = 1'b0;
    op_done = 1'b0;
  endtask
  task flags(input logic [2:0] f);
    check("flags", {ps1, ps2, es}, f);
  endtask
  // Watchdog against a hang.
  initial
  begin
    #500000;
    bad_count++;
    close_out;
  end
  // Main sequence.
  initial
  begin
    {cmd_valid, op_start, op_done, soft_reset, rst_n} = 5'h00;
    cmd_class = 4'h0;
    op_kind = 2'h0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    sweep(12'hFFF);
    arr(1, 0, 1);
    host.frame(8'hD0, 0);
    check("res", n_res, 0);
    host.frame(8'hB0, 16);
    flags(3'h4);
    check("ready", ready, 1);
    sweep(12'h835);
    host.frame(8'hD0, 16);
    flags(3'h0);
    check("busy", {ready, kind}, 3'h1);
    host.frame(8'hB0, 0);
    check("susp", n_susp, 1);
    arr(0, 1, 0);
    check("ready", ready, 1);
    repeat (300) @(negedge clk);
    arr(1, 0, 3);
    host.frame(8'hB0, 0);
    flags(3'h1);
    sweep(12'h87F);
    arr(1, 0, 2);
    host.frame(8'hB0, 0);
    flags(3'h3);
    sweep(12'h82B);
    host.frame(8'hD0, 0);
    flags(3'h1);
    check("kind", kind, 2);
    arr(0, 1, 0);
    host.frame(8'hD0, 0);
    flags(3'h0);
    check("kind", kind, 3);
    repeat (300) @(negedge clk);
    host.frame(8'hB0, 0);
    flags(3'h1);
    host.frame(8'hD0, 0);
    flags(3'h0);
    arr(0, 1, 0);
    repeat (300) @(negedge clk);
    arr(1, 0, 2);
    host.frame(8'hB0, 0);
    flags(3'h2);
    gate(4'hA, 1);
    flags(3'h0);
    arr(1, 0, 1);
    host.frame(8'hB0, 0);
    flags(3'h4);
    @(negedge clk) soft_reset = 1'b1;
    @(negedge clk) soft_reset = 1'b0;
    flags(3'h0);
    check("ready", ready, 1);
    check("susp", n_susp, 6);
    check("res", n_res, 4);
    close_out;
  end
endmodule
bind fsrg_gate fsrg_checker chk (.clk, .rst_n, .cmd_valid, .cmd_class, .soft_reset, .gate_allow_reg,
  .gate_refuse_reg, .suspend_cmd_reg, .resume_cmd_reg, .resume_kind_reg, .reset_cmd_reg, .ready_reg,
  .resuming_reg, .prog_suspend_buf_one_flag, .prog_suspend_buf_two_flag, .erase_suspend_flag);
